// File: alu_pkg.sv
// Shared constants and types of the byte/word arithmetic, logic and shift datapath.
// Assumes one clock domain; the decoder supplies operation codes from alu_op_e.
package alu_pkg;

	localparam int unsigned DATA_W    = 16;
	localparam int unsigned BYTE_W    = 8;
	localparam int unsigned FLAGS_W   = 8;
	localparam int unsigned ADDR_W    = 2;

	// Condition flag bit positions
	localparam int unsigned FLAG_C    = 0;
	localparam int unsigned FLAG_V    = 1;
	localparam int unsigned FLAG_Z    = 2;
	localparam int unsigned FLAG_N    = 3;
	localparam int unsigned FLAG_H    = 5;
	localparam logic [FLAGS_W-1:0] FLAGS_RESET = 8'h00;

	// Register port offsets
	localparam logic [ADDR_W-1:0] REG_FLAGS  = 2'h0;
	localparam logic [ADDR_W-1:0] REG_RESULT = 2'h1;

	// Decimal adjust constants
	localparam logic [7:0] BCD_LOW_FIX  = 8'h06;
	localparam logic [7:0] BCD_HIGH_FIX = 8'h60;
	localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
	localparam logic [7:0] BCD_BYTE_MAX  = 8'h99;

	// Quick word add/subtract constants
	localparam logic [7:0] QUICK_ONE = 8'h01;
	localparam logic [7:0] QUICK_TWO = 8'h02;

	typedef enum logic [4:0] {
		add_op, sub_op, add_with_carry, sub_with_carry,
		increment_op, decrement_op, quick_word_add, quick_word_sub,
		decimal_adjust_add, decimal_adjust_sub, unsigned_multiply, unsigned_divide,
		compare_op, negate_op, and_op, or_op, xor_op, not_op,
		arith_shift_left, arith_shift_right, logic_shift_left, logic_shift_right,
		rotate_left, rotate_right, rotate_carry_left, rotate_carry_right
	} alu_op_e;

	typedef struct packed {
		logic              c;
		logic              v;
		logic              h;
		logic [DATA_W-1:0] res;
	} arith_s;

endpackage : alu_pkg

// File: shift_unit.sv
// One-bit shifts and rotates of a byte operand.
// Assumes the caller only presents shift or rotate codes; others pass the operand.
`timescale 1ns/1ps
module shift_unit #(
	parameter int unsigned WIDTH = 8
) (
	input  wire logic [WIDTH-1:0]    operand,
	input  wire logic                carry_in,
	input  wire alu_pkg::alu_op_e    kind,
	output logic      [WIDTH-1:0]    shifted,
	output logic                     carry_out,
	output logic                     overflow
);
	import alu_pkg::*;

	if (WIDTH < 2) begin : g_check
		$error("shift_unit needs WIDTH of at least 2");
	end

	always_comb begin
		shifted   = operand;
		carry_out = carry_in;
		overflow  = 1'b0;
		case (kind)
			arith_shift_left: begin
				shifted   = {operand[WIDTH-2:0], 1'b0};
				carry_out = operand[WIDTH-1];
				overflow  = operand[WIDTH-1] ^ operand[WIDTH-2];
			end
			logic_shift_left: begin
				shifted   = {operand[WIDTH-2:0], 1'b0};
				carry_out = operand[WIDTH-1];
			end
			arith_shift_right: begin
				shifted   = {operand[WIDTH-1], operand[WIDTH-1:1]};
				carry_out = operand[0];
			end
			logic_shift_right: begin
				shifted   = {1'b0, operand[WIDTH-1:1]};
				carry_out = operand[0];
			end
			rotate_left: begin
				shifted   = {operand[WIDTH-2:0], operand[WIDTH-1]};
				carry_out = operand[WIDTH-1];
			end
			rotate_right: begin
				shifted   = {operand[0], operand[WIDTH-1:1]};
				carry_out = operand[0];
			end
			rotate_carry_left: begin
				shifted   = {operand[WIDTH-2:0], carry_in};
				carry_out = operand[WIDTH-1];
			end
			rotate_carry_right: begin
				shifted   = {carry_in, operand[WIDTH-1:1]};
				carry_out = operand[0];
			end
			default: begin
				shifted   = operand;
			end
		endcase
	end

endmodule : shift_unit

// File: divide_unit.sv
// Restoring unsigned division of a double-width dividend by a single-width divisor.
// Assumes the caller keeps the quotient within DW bits; higher bits are dropped.
`timescale 1ns/1ps
module divide_unit #(
	parameter int unsigned NW = 16,
	parameter int unsigned DW = 8
) (
	input  wire logic [NW-1:0] dividend,
	input  wire logic [DW-1:0] divisor,
	output logic      [DW-1:0] quotient,
	output logic      [DW-1:0] remainder,
	output logic               div_zero
);
	logic [DW:0]   part;
	logic [NW-1:0] quo;

	if (NW != 2 * DW) begin : g_check
		$error("divide_unit needs NW equal to twice DW");
	end

	always_comb begin
		part = '0;
		quo  = '0;
		for (int i = NW - 1; i >= 0; i--) begin
			part = {part[DW-1:0], dividend[i]};
			if (part >= {1'b0, divisor}) begin
				part   = part - {1'b0, divisor};
				quo[i] = 1'b1;
			end
		end
	end

	assign quotient  = quo[DW-1:0];
	assign remainder = part[DW-1:0];
	assign div_zero  = (divisor == '0);

endmodule : divide_unit

// File: alu_core.sv
// Byte/word arithmetic, logic and shift datapath with its condition flags.
// Assumes the decoder presents one operation per op_valid cycle and writes back
// result when result_wr pulses; byte results use the low byte only.
//
// Summary of operation
// - Add or subtract two registers; add immediate; immediate subtract is refused.
// - Word add and subtract only register to register; word immediate refused.
// - Add and subtract with carry on bytes, register or immediate source.
// - Increment and decrement change a byte register by exactly one.
// - Quick word add and subtract adjust a register by one or two.
// - Decimal adjust corrects a byte to packed BCD using current flags.
// - Unsigned multiply gives the full 16-bit product of two bytes.
// - Unsigned divide gives 8-bit quotient and 8-bit remainder of 16/8.
// - Compare subtracts and updates flags only, no write back.
// - Word compare register to register only; immediate compare is byte only.
// - Negate replaces a byte with zero minus its value.
// - AND, OR, XOR combine a byte with register or immediate data.
// - NOT inverts every bit of a byte register.
// - Arithmetic shifts left and right on a byte, written back.
// - Logical shifts left and right on a byte, written back.
// - Plain rotates circulate a byte without the carry flag.
// - Rotates through carry form a nine-bit loop with the carry flag.
// - Condition flags hold negative, zero, overflow, carry and half carry; read and updated.
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module alu_core (
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	input  wire logic                          op_valid,
	input  wire alu_pkg::alu_op_e              op_code,
	input  wire logic                          op_word,
	input  wire logic                          op_imm,
	input  wire logic [alu_pkg::DATA_W-1:0]    dst_val,
	input  wire logic [alu_pkg::DATA_W-1:0]    src_val,
	input  wire logic [alu_pkg::BYTE_W-1:0]    imm_val,
	input  wire logic [alu_pkg::ADDR_W-1:0]    reg_addr,
	input  wire logic [alu_pkg::DATA_W-1:0]    reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic      [alu_pkg::DATA_W-1:0]    reg_rdata,
	output logic      [alu_pkg::DATA_W-1:0]    result,
	output logic                               result_wr,
	output logic                               result_word,
	output logic                               op_refused,
	output logic      [alu_pkg::FLAGS_W-1:0]   flags
);
	import alu_pkg::*;

	typedef struct packed {
		logic [DATA_W-1:0]  result;
		logic               wr;
		logic               word;
		logic               refused;
		logic [FLAGS_W-1:0] flags;
		logic [DATA_W-1:0]  rdata;
	} state_s;

	state_s st_reg;
	state_s st_next;

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic arith_s addsub(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b,
	                                  input logic cin, input logic sub, input logic word);
		logic [DATA_W-1:0] bb;
		logic              ci;
		logic [DATA_W:0]   sw;
		logic [BYTE_W:0]   sb;
		logic [12:0]       hw;
		logic [4:0]        hb;
		arith_s            r;
		bb    = sub ? ~b : b;
		ci    = sub ? ~cin : cin;
		sw    = {1'b0, a} + {1'b0, bb} + {{DATA_W{1'b0}}, ci};
		sb    = {1'b0, a[7:0]} + {1'b0, bb[7:0]} + {{BYTE_W{1'b0}}, ci};
		hw    = {1'b0, a[11:0]} + {1'b0, bb[11:0]} + {12'h000, ci};
		hb    = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
		r.res = word ? sw[DATA_W-1:0] : {8'h00, sb[7:0]};
		r.c   = sub ^ (word ? sw[DATA_W] : sb[BYTE_W]);
		r.h   = sub ^ (word ? hw[12] : hb[4]);
		r.v   = word ? ((a[15] == bb[15]) && (sw[15] != a[15]))
		             : ((a[7] == bb[7]) && (sb[7] != a[7]));
		return r;
	endfunction : addsub

	function automatic logic [1:0] nz_of(input logic [DATA_W-1:0] r, input logic word);
		return word ? {r[15], r == '0} : {r[7], r[7:0] == 8'h00};
	endfunction : nz_of

	function automatic logic refused_op(input alu_op_e op, input logic word, input logic imm,
	                                    input logic [BYTE_W-1:0] k);
		logic bad;
		bad = 1'b0;
		case (op)
			add_op, compare_op:                bad = word && imm;
			sub_op:                            bad = imm;
			add_with_carry, sub_with_carry,
			and_op, or_op, xor_op:             bad = word;
			quick_word_add, quick_word_sub:    bad = (k != QUICK_ONE) && (k != QUICK_TWO);
			default:                           bad = word || imm;
		endcase
		return bad;
	endfunction : refused_op

	////////////////////////////////////////////////////////////////////////////
	// Shared units

	logic [BYTE_W-1:0] sh_res;
	logic              sh_c;
	logic              sh_v;
	logic [BYTE_W-1:0] dv_quo;
	logic [BYTE_W-1:0] dv_rem;
	logic              dv_zero;

	shift_unit #(.WIDTH(BYTE_W)) u_shift (
		.operand   (dst_val[BYTE_W-1:0]),
		.carry_in  (st_reg.flags[FLAG_C]),
		.kind      (op_code),
		.shifted   (sh_res),
		.carry_out (sh_c),
		.overflow  (sh_v)
	);

	divide_unit #(.NW(DATA_W), .DW(BYTE_W)) u_divide (
		.dividend  (dst_val),
		.divisor   (src_val[BYTE_W-1:0]),
		.quotient  (dv_quo),
		.remainder (dv_rem),
		.div_zero  (dv_zero)
	);

	////////////////////////////////////////////////////////////////////////////
	// Next state

	logic [DATA_W-1:0] bsel;
	arith_s            ar;
	logic [7:0]        bcd_fix;
	logic              bcd_c;
	logic [DATA_W-1:0] res_v;
	logic              wr_v;
	logic              word_v;
	logic              n_v, z_v, v_v, c_v, h_v;
	logic              upd_nz, upd_v, upd_c, upd_h;
	logic              c_in;

	assign bsel = op_imm ? {8'h00, imm_val} : src_val;
	assign c_in = st_reg.flags[FLAG_C];

	always_comb begin
		st_next         = st_reg;
		st_next.wr      = 1'b0;
		st_next.refused = 1'b0;
		st_next.rdata   = '0;
		ar      = addsub(dst_val, bsel, 1'b0, 1'b0, 1'b0);
		bcd_fix = 8'h00;
		bcd_c   = c_in;
		res_v   = '0;
		wr_v    = 1'b1;
		word_v  = 1'b0;
		{n_v, z_v, v_v, c_v, h_v}         = 5'b0;
		{upd_nz, upd_v, upd_c, upd_h}     = 4'b0;
		// Software flag write; a same-cycle accepted operation overrides only the flag bits it updates below
		if (reg_wr && (reg_addr == REG_FLAGS)) begin
			st_next.flags = reg_wdata[FLAGS_W-1:0];
		end
		case (op_code)
			add_op, sub_op, compare_op: begin
				ar = addsub(dst_val, bsel, 1'b0, op_code != add_op, op_word);
				word_v = op_word;
				wr_v   = (op_code != compare_op);
			end
			add_with_carry, sub_with_carry: begin
				ar = addsub(dst_val, bsel, c_in, op_code == sub_with_carry, 1'b0);
			end
			increment_op, decrement_op: begin
				ar = addsub(dst_val, {8'h00, QUICK_ONE}, 1'b0, op_code == decrement_op, 1'b0);
			end
			negate_op: begin
				ar = addsub('0, dst_val, 1'b0, 1'b1, 1'b0);
			end
			default: begin
				ar = addsub(dst_val, bsel, 1'b0, 1'b0, 1'b0);
			end
		endcase
		case (op_code)
			add_op, sub_op, compare_op, negate_op: begin
				res_v = ar.res;
				{n_v, z_v} = nz_of(ar.res, word_v);
				{v_v, c_v, h_v} = {ar.v, ar.c, ar.h};
				{upd_nz, upd_v, upd_c, upd_h} = 4'b1111;
			end
			add_with_carry, sub_with_carry: begin
				res_v = ar.res;
				{n_v, z_v} = nz_of(ar.res, 1'b0);
				z_v = z_v & st_reg.flags[FLAG_Z];  // Zero only sticks across a chain
				{v_v, c_v, h_v} = {ar.v, ar.c, ar.h};
				{upd_nz, upd_v, upd_c, upd_h} = 4'b1111;
			end
			increment_op, decrement_op: begin
				res_v = ar.res;
				{n_v, z_v} = nz_of(ar.res, 1'b0);
				v_v = ar.v;
				{upd_nz, upd_v} = 2'b11;
			end
			quick_word_add: begin
				res_v  = dst_val + {8'h00, imm_val};
				word_v = 1'b1;
			end
			quick_word_sub: begin
				res_v  = dst_val - {8'h00, imm_val};
				word_v = 1'b1;
			end
			decimal_adjust_add: begin
				if (st_reg.flags[FLAG_H] || (dst_val[3:0] > BCD_DIGIT_MAX)) bcd_fix = bcd_fix | BCD_LOW_FIX;
				if (c_in || (dst_val[7:0] > BCD_BYTE_MAX)) begin
					bcd_fix = bcd_fix | BCD_HIGH_FIX;
					bcd_c   = 1'b1;
				end
				res_v = {8'h00, dst_val[7:0] + bcd_fix};
				{n_v, z_v} = nz_of(res_v, 1'b0);
				c_v = bcd_c;
				{upd_nz, upd_v, upd_c} = 3'b111;
			end
			decimal_adjust_sub: begin
				if (st_reg.flags[FLAG_H]) bcd_fix = bcd_fix | BCD_LOW_FIX;
				if (c_in) bcd_fix = bcd_fix | BCD_HIGH_FIX;
				res_v = {8'h00, dst_val[7:0] - bcd_fix};
				{n_v, z_v} = nz_of(res_v, 1'b0);
				c_v = c_in;
				{upd_nz, upd_v, upd_c} = 3'b111;
			end
			unsigned_multiply: begin
				res_v  = {8'h00, dst_val[7:0]} * {8'h00, src_val[7:0]};
				word_v = 1'b1;
			end
			unsigned_divide: begin
				res_v  = dv_zero ? dst_val : {dv_rem, dv_quo};
				word_v = 1'b1;
				{n_v, z_v} = {src_val[7], dv_zero};
				upd_nz = 1'b1;
			end
			and_op, or_op, xor_op, not_op: begin
				case (op_code)
					and_op:  res_v = {8'h00, dst_val[7:0] & bsel[7:0]};
					or_op:   res_v = {8'h00, dst_val[7:0] | bsel[7:0]};
					xor_op:  res_v = {8'h00, dst_val[7:0] ^ bsel[7:0]};
					default: res_v = {8'h00, ~dst_val[7:0]};
				endcase
				{n_v, z_v} = nz_of(res_v, 1'b0);
				{upd_nz, upd_v} = 2'b11;
			end
			default: begin
				res_v = {8'h00, sh_res};
				{n_v, z_v} = nz_of(res_v, 1'b0);
				{v_v, c_v} = {sh_v, sh_c};
				{upd_nz, upd_v, upd_c} = 3'b111;
			end
		endcase
		if (op_valid) begin
			if (refused_op(op_code, op_word, op_imm, imm_val)) begin
				st_next.refused = 1'b1;
			end else begin
				st_next.wr   = wr_v;
				st_next.word = word_v;
				if (wr_v) st_next.result = res_v;
				if (upd_nz) {st_next.flags[FLAG_N], st_next.flags[FLAG_Z]} = {n_v, z_v};
				if (upd_v) st_next.flags[FLAG_V] = v_v;
				if (upd_c) st_next.flags[FLAG_C] = c_v;
				if (upd_h) st_next.flags[FLAG_H] = h_v;
			end
		end
		if (reg_rd) begin
			case (reg_addr)
				REG_FLAGS:  st_next.rdata = {8'h00, st_reg.flags};
				REG_RESULT: st_next.rdata = st_reg.result;
				default:    st_next.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg       <= '0;
			st_reg.flags <= FLAGS_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata   = st_reg.rdata;
	assign result      = st_reg.result;
	assign result_wr   = st_reg.wr;
	assign result_word = st_reg.word;
	assign op_refused  = st_reg.refused;
	assign flags       = st_reg.flags;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_sub_imm_refused: assert property (
		op_valid && op_code == sub_op && op_imm |=> op_refused && !result_wr)
		else $error("immediate subtract not refused");
	chk_word_imm_add: assert property (
		op_valid && op_code == add_op && op_imm && op_word |=> op_refused && !result_wr)
		else $error("word immediate add not refused");
	chk_carry_add: assert property (
		op_valid && op_code == add_with_carry && !op_imm && !op_word |=>
		result[7:0] == 8'($past(dst_val[7:0]) + $past(src_val[7:0]) + {7'h00, $past(flags[FLAG_C])}))
		else $error("add with carry result wrong");
	chk_inc_step: assert property (
		op_valid && op_code == increment_op && !op_imm && !op_word |=>
		result_wr && result[7:0] == 8'($past(dst_val[7:0]) + 8'h01))
		else $error("increment not by one");
	chk_quick_sub_two: assert property (
		op_valid && op_code == quick_word_sub && imm_val == QUICK_TWO |=>
		result_word && result == 16'($past(dst_val) - 16'h0002))
		else $error("quick subtract by two wrong");
	chk_bcd_low: assert property (
		op_valid && op_code == decimal_adjust_add && !op_imm && !op_word && dst_val[7:0] == 8'h0A &&
		flags[FLAG_C] == 1'b0 && flags[FLAG_H] == 1'b0 && !reg_wr |=> result[7:0] == 8'h10)
		else $error("decimal adjust low digit wrong");
	chk_multiply: assert property (
		op_valid && op_code == unsigned_multiply && !op_imm && !op_word |=>
		result == {8'h00, $past(dst_val[7:0])} * {8'h00, $past(src_val[7:0])})
		else $error("multiply product wrong");
	chk_divide: assert property (
		op_valid && op_code == unsigned_divide && !op_imm && !op_word && dst_val[15:8] < src_val[7:0] |=>
		16'(result[7:0] * $past(src_val[7:0])) + {8'h00, result[15:8]} == $past(dst_val))
		else $error("divide does not reconstruct dividend");
	chk_compare_flags: assert property (
		op_valid && op_code == compare_op && !op_word && !reg_wr |=>
		!result_wr && $stable(result) && flags[FLAG_Z] == ($past(dst_val[7:0]) == $past(bsel[7:0])))
		else $error("compare wrote back or zero flag wrong");
	chk_word_cmp_imm: assert property (
		op_valid && op_code == compare_op && op_word && op_imm && !reg_wr |=> op_refused && $stable(flags))
		else $error("word immediate compare accepted");
	chk_negate: assert property (
		op_valid && op_code == negate_op && !op_imm && !op_word |=>
		result[7:0] == 8'(8'h00 - $past(dst_val[7:0])))
		else $error("negate wrong");
	chk_not_keeps_c: assert property (
		op_valid && op_code == not_op && !op_imm && !op_word && !reg_wr |=>
		result[7:0] == ~$past(dst_val[7:0]) && flags[FLAG_C] == $past(flags[FLAG_C]))
		else $error("not wrong or carry disturbed");
	chk_shift_right_sign: assert property (
		op_valid && op_code == arith_shift_right && !op_imm && !op_word |=>
		result[7:6] == {2{$past(dst_val[7])}} && flags[FLAG_C] == $past(dst_val[0]))
		else $error("arithmetic right shift wrong");
	chk_rotate_carry: assert property (
		op_valid && op_code == rotate_carry_left && !op_imm && !op_word |=>
		{flags[FLAG_C], result[7:0]} == {$past(dst_val[7:0]), $past(flags[FLAG_C])})
		else $error("rotate through carry wrong");
	chk_flags_write: assert property (
		reg_wr && reg_addr == REG_FLAGS && !op_valid |=> flags == $past(reg_wdata[7:0]))
		else $error("flag write lost");

	cov_word_add:    cover property (op_valid && op_code == add_op && op_word ##1 result_wr);
	cov_divide_zero: cover property (op_valid && op_code == unsigned_divide && src_val[7:0] == 8'h00);
	cov_refused:     cover property (op_refused);
	cov_flag_read:   cover property (reg_rd && reg_addr == REG_FLAGS);

endmodule : alu_core

// File: gpr_model.sv
// Register file model standing where the decoder and general registers sit.
// Assumes the bench loads both operands with ld one cycle before the operation.
`timescale 1ns/1ps
module gpr_model (
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic                       ld,
	input  wire logic [alu_pkg::DATA_W-1:0] ld_dst,
	input  wire logic [alu_pkg::DATA_W-1:0] ld_src,
	input  wire logic [alu_pkg::DATA_W-1:0] result,
	input  wire logic                       result_wr,
	input  wire logic                       result_word,
	output logic      [alu_pkg::DATA_W-1:0] dst_val,
	output logic      [alu_pkg::DATA_W-1:0] src_val
);
	import alu_pkg::*;
	logic [DATA_W-1:0] dst_reg;
	logic [DATA_W-1:0] src_reg;
	assign dst_val = dst_reg;
	assign src_val = src_reg;
	// Byte write-back keeps the upper byte of the destination
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dst_reg <= 16'h0000;
			src_reg <= 16'h0000;
		end else if (ld) begin
			dst_reg <= ld_dst;
			src_reg <= ld_src;
		end else if (result_wr && result_word) begin
			dst_reg <= result;
		end else if (result_wr) begin
			dst_reg[7:0] <= result[7:0];
		end
	end
endmodule : gpr_model

// File: byte_word_alu_ops_tb_top.sv
// Self-checking bench for alu_core with a register file model on the far side.
// Assumes a 250 MHz clock and the operation and register port timing of alu_core.
`timescale 1ns/1ps
module byte_word_alu_ops_tb_top;
	import alu_pkg::*;
	typedef struct {alu_op_e op; logic w; logic i; logic [7:0] iv; logic [15:0] d; logic [15:0] s;
		logic cin; logic [15:0] res; logic [1:0] kind; logic c;} row_s;
	logic        clk = 1'h0, rst_n = 1'h0, op_valid = 1'h0, op_word = 1'h0, op_imm = 1'h0;
	logic        ld = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, result_wr, result_word, op_refused;
	alu_op_e     op_code = add_op;
	logic [7:0]  imm_val = 8'h00, flags;
	logic [1:0]  reg_addr = 2'h0;
	logic [15:0] reg_wdata = 16'h0, ld_dst = 16'h0, ld_src = 16'h0, dst_val, src_val, reg_rdata, result, rd;
	int          err_total = 0, n_tests = 0, cycles = 0;
	// Kind: 0 written back, 1 refused, 2 flags only
	row_s rows[34] = '{
		'{add_op,0,0,8'h00,16'hF0,16'h20,0,16'h10,0,1},
		'{add_op,1,0,8'h00,16'h1234,16'h0F00,0,16'h2134,0,0},
		'{add_op,0,1,8'h05,16'h10,16'h0,0,16'h15,0,0},
		'{sub_op,0,1,8'h01,16'h10,16'h0,0,16'h0,1,0},
		'{add_op,1,1,8'h01,16'h10,16'h0,1,16'h0,1,1},
		'{add_with_carry,0,0,8'h00,16'h10,16'h01,1,16'h12,0,0},
		'{sub_with_carry,0,1,8'h01,16'h10,16'h0,1,16'h0E,0,0},
		'{increment_op,0,0,8'h00,16'hFF,16'h0,1,16'h00,0,1},
		'{decrement_op,0,0,8'h00,16'h00,16'h0,0,16'hFF,0,0},
		'{quick_word_add,0,0,8'h02,16'hFFFF,16'h0,0,16'h0001,0,0},
		'{quick_word_sub,0,0,8'h01,16'h0000,16'h0,1,16'hFFFF,0,1},
		'{quick_word_add,0,0,8'h03,16'h10,16'h0,0,16'h0,1,0},
		'{decimal_adjust_add,0,0,8'h00,16'h9A,16'h0,0,16'h00,0,1},
		'{decimal_adjust_sub,0,0,8'h00,16'h66,16'h0,1,16'h06,0,1},
		'{unsigned_multiply,0,0,8'h00,16'hFF,16'hFF,0,16'hFE01,0,0},
		'{unsigned_divide,0,0,8'h00,16'h0107,16'h10,0,16'h0710,0,0},
		'{compare_op,0,1,8'h05,16'h03,16'h0,0,16'h0,2,1},
		'{compare_op,1,1,8'h05,16'h03,16'h0,0,16'h0,1,0},
		'{negate_op,0,0,8'h00,16'h01,16'h0,0,16'hFF,0,1},
		'{and_op,0,0,8'h00,16'hF0,16'h3C,1,16'h30,0,1},
		'{xor_op,1,0,8'h00,16'hFF,16'h0F,0,16'h0,1,0},
		'{not_op,0,0,8'h00,16'h5A,16'h0,0,16'hA5,0,0},
		'{arith_shift_left,0,0,8'h00,16'h81,16'h0,0,16'h02,0,1},
		'{arith_shift_right,0,0,8'h00,16'h81,16'h0,0,16'hC0,0,1},
		'{logic_shift_left,0,0,8'h00,16'h40,16'h0,1,16'h80,0,0},
		'{rotate_left,0,0,8'h00,16'h81,16'h0,0,16'h03,0,1},
		'{rotate_carry_left,0,0,8'h00,16'h80,16'h0,1,16'h01,0,1},
		'{rotate_carry_right,0,0,8'h00,16'h01,16'h0,0,16'h00,0,1},
		'{sub_op,0,0,8'h00,16'h10,16'h20,0,16'hF0,0,1},
		'{decimal_adjust_add,0,0,8'h00,16'h0A,16'h0,0,16'h10,0,0},
		'{unsigned_divide,0,0,8'h00,16'h1234,16'h0,0,16'h1234,0,0},
		'{or_op,0,1,8'h0F,16'hF0,16'h0,0,16'hFF,0,0},
		'{logic_shift_right,0,0,8'h00,16'h81,16'h0,0,16'h40,0,1},
		'{rotate_right,0,0,8'h00,16'h01,16'h0,0,16'h80,0,1}
	};
	alu_core i_dut (.clk, .rst_n, .op_valid, .op_code, .op_word, .op_imm, .dst_val, .src_val, .imm_val,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .result, .result_wr, .result_word,
		.op_refused, .flags);
	gpr_model i_gpr (.clk, .rst_n, .ld, .ld_dst, .ld_src, .result, .result_wr, .result_word, .dst_val, .src_val);
	always #2 clk = ~clk;
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic reg_write(input logic [1:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask : reg_write
	task automatic reg_read(input logic [1:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1;
		d = reg_rdata;
	endtask : reg_read
	// Loads operands, issues one operation, returns in the answer cycle
	task automatic run_op(input row_s r);
		@(posedge clk);
		ld <= 1'h1;
		ld_dst <= r.d;
		ld_src <= r.s;
		@(posedge clk);
		ld <= 1'h0;
		op_valid <= 1'h1;
		op_code <= r.op;
		op_word <= r.w;
		op_imm <= r.i;
		imm_val <= r.iv;
		@(posedge clk);
		op_valid <= 1'h0;
		#1;
	endtask : run_op
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : conclude
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			err_total++;
			$display("MISMATCH t=%0t timeout", $time);
			conclude();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		#1;
		chk(flags, 16'h0, "reset flags");
		chk(result, 16'h0, "reset result");
		$display("reset test done");
		foreach (rows[k]) begin
			logic wide;
			wide = rows[k].w || (rows[k].op inside {quick_word_add, quick_word_sub, unsigned_multiply, unsigned_divide});
			reg_write(REG_FLAGS, {15'h0, rows[k].cin});
			run_op(rows[k]);
			chk(result_wr, rows[k].kind == 2'h0, "write pulse");
			chk(op_refused, rows[k].kind == 2'h1, "refusal");
			if (rows[k].kind == 2'h0) chk(result, rows[k].res, "result");
			if (rows[k].kind == 2'h0) chk(result_word, {15'h0, wide}, "word size");
			chk(flags[FLAG_C], rows[k].c, "carry");
			$display("row %0d done", k);
		end
		reg_write(REG_FLAGS, 16'hFFAA);
		reg_read(REG_FLAGS, rd);
		chk(rd, 16'h00AA, "flag readback");
		reg_read(2'h3, rd);
		chk(rd, 16'h0, "unmapped read");
		$display("register test done");
		reg_write(REG_FLAGS, 16'h0001);
		run_op('{increment_op,0,0,8'h00,16'h12FF,16'h0,1,16'h0,0,1});
		@(posedge clk);
		#1;
		chk(dst_val, 16'h1200, "byte write-back");
		reg_read(REG_FLAGS, rd);
		chk(rd, 16'h0005, "increment flags");
		$display("write-back test done");
		run_op('{compare_op,1,0,8'h00,16'h1234,16'h1234,0,16'h0,2,0});
		@(posedge clk);
		#1;
		chk(dst_val, 16'h1234, "compare keeps destination");
		reg_read(REG_FLAGS, rd);
		chk(rd, 16'h0004, "compare flags");
		$display("compare test done");
		// Add then add with carry on consecutive edges
		@(posedge clk);
		ld <= 1'h1;
		ld_dst <= 16'h00FF;
		ld_src <= 16'h0001;
		@(posedge clk);
		ld <= 1'h0;
		op_valid <= 1'h1;
		op_code <= add_op;
		op_word <= 1'h0;
		op_imm <= 1'h0;
		@(posedge clk);
		op_code <= add_with_carry;
		@(posedge clk);
		op_valid <= 1'h0;
		#1;
		chk(result, 16'h0001, "carry chain");
		chk(flags[FLAG_C], 1'h1, "chain carry");
		reg_read(REG_RESULT, rd);
		chk(rd, 16'h0001, "result readback");
		$display("back-to-back test done");
		@(posedge clk);
		rst_n <= 1'h0;
		#1;
		chk(flags, 16'h0, "mid-run reset");
		chk(result, 16'h0, "mid-run reset result");
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		#1;
		chk(result_wr, 16'h0, "no write after release");
		run_op(rows[0]);
		chk(result, rows[0].res, "first op after release");
		chk(flags[FLAG_C], rows[0].c, "carry after release");
		$display("second reset test done");
		conclude();
	end
endmodule : byte_word_alu_ops_tb_top
